//--- dv/cam_port_chk.sv
// Port-level timing checks of the camera capture port.
// Bound to cam_port; sees its ports only, one clock domain.
`timescale 1ns/1ps

module cam_port_chk
(
    input logic        sys_clk,
    input logic        nrst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic        pready,
    input logic        pslverr,
    input logic        line_sync_oe,
    input logic        frame_sync_oe,
    input logic        sensor_clk_out,
    input logic        dma_valid,
    input logic [1:0]  dma_chan,
    input logic [63:0] dma_data,
    input logic        dma_ready,
    input logic        irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    property p_ready_access;
        psel && penable |-> pready;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("no ready in access");
    property p_err_bad;
        psel && !penable && paddr > 12'h01C |=> pslverr;
    endproperty
    a_err_bad: assert property (p_err_bad) else $error("unmapped not refused");
    property p_err_ok;
        psel && !penable && paddr <= 12'h01C && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    a_err_ok: assert property (p_err_ok) else $error("mapped refused");
    property p_dma_hold;
        dma_valid && !dma_ready |=> dma_valid && $stable(dma_data) && $stable(dma_chan);
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("dma word not held");
    property p_chan_range;
        dma_valid |-> dma_chan != 2'h3;
    endproperty
    a_chan_range: assert property (p_chan_range) else $error("bad fifo index");
    property p_clk_half;
        $changed(sensor_clk_out) |=> $stable(sensor_clk_out);
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("sensor clock too fast");
    property p_oe_pair;
        line_sync_oe == frame_sync_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("sync enables differ");
    property p_irq_clear;
        psel && penable && pwrite && paddr == 12'h014 && pwdata[2:0] == 3'h7 |-> ##2 !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq after clear");
    c_dma: cover property (dma_valid && dma_ready);
    c_irq: cover property ($rose(irq));
    c_err: cover property (psel && penable && pslverr);
endmodule

bind cam_port cam_port_chk i_chk
(
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .line_sync_oe(line_sync_oe), .frame_sync_oe(frame_sync_oe),
    .sensor_clk_out(sensor_clk_out), .dma_valid(dma_valid), .dma_chan(dma_chan),
    .dma_data(dma_data), .dma_ready(dma_ready), .irq(irq)
);

//--- dv/cam_sensor_model.sv
// Behavioural image sensor: 8 MHz pixel clock inside frames only, high syncs.
// Driven by task calls from the bench.
`timescale 1ns/1ps

module cam_sensor_model
(
    output logic       pclk,
    output logic [7:0] data,
    output logic       lsync,
    output logic       fsync
);
    initial
    begin
        pclk = 1'b0;
        data = 8'h00;
        lsync = 1'b0;
        fsync = 1'b0;
    end

    task automatic send_frame(input int lines, input int nb, input logic [7:0] base);
        fsync = 1'b1;
        for (int l = 0; l < lines; l++)
        begin
            for (int b = 0; b < nb + 3; b++)
            begin
                lsync = (b < nb);
                data = (b < nb) ? base + 8'(l * nb + b) : ~data;
                #62.5 pclk = 1'b1;
                #62.5 pclk = 1'b0;
            end
        end
        fsync = 1'b0;
        data = ~data;
    endtask
endmodule

//--- dv/camera_quick_capture_port_tb.sv
// Self-checking bench of the camera capture port: APB master, DMA sink, sensor.
// Needs cam_port, its register header, cam_sensor_model and the bound checker.
`timescale 1ns/1ps
`include "cam_port_regs.vh"
`define CHK(nm, ex, got) check(nm, 64'(ex), 64'(got))

module camera_quick_capture_port_tb;
    logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, dma_ready;
    logic        line_sync_out, line_sync_oe, frame_sync_out, frame_sync_oe, sensor_clk_out;
    logic        s_pclk, s_lsync, s_fsync, dma_valid, errv;
    logic [7:0]  s_data;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [1:0]  dma_chan;
    logic [63:0] dma_data;
    logic [63:0] got_d[$];
    logic [1:0]  got_c[$];
    int          fail_count, compares, cycles;
    wire         line_pin = line_sync_oe ? line_sync_out : s_lsync;
    wire         frame_pin = frame_sync_oe ? frame_sync_out : s_fsync;

    cam_port i_dut
    (
        .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sensor_pixel_clock(s_pclk), .pixel_data_bus(s_data), .line_sync_in(line_pin),
        .line_sync_out(line_sync_out), .line_sync_oe(line_sync_oe), .frame_sync_in(frame_pin),
        .frame_sync_out(frame_sync_out), .frame_sync_oe(frame_sync_oe),
        .sensor_clk_out(sensor_clk_out), .dma_valid(dma_valid), .dma_chan(dma_chan),
        .dma_data(dma_data), .dma_ready(dma_ready), .irq(irq)
    );

    cam_sensor_model i_sen
    (
        .pclk(s_pclk), .data(s_data), .lsync(s_lsync), .fsync(s_fsync)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (dma_valid === 1'b1 && dma_ready === 1'b1)
        begin
            got_d.push_back(dma_data);
            got_c.push_back(dma_chan);
        end
        if (cycles == 60000)
        begin
            fail_count++;
            $display("FAIL timeout expected 0 seen %0d", cycles);
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task check(input string nm, input logic [63:0] ex, input logic [63:0] got);
        compares++;
        if (got !== ex)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv, errv);
    endtask

    task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0, rdv, errv);
        `CHK(nm, ex, rdv);
    endtask

    function automatic logic [63:0] exp_word(input logic [7:0] b, input int stp,
                                             input logic [7:0] m);
        for (int k = 0; k < 8; k++)
            exp_word[8*k +: 8] = (b + 8'(stp * k)) & m;
    endfunction

    task cap(input int lines, input int nb, input logic [7:0] base);
        got_d.delete();
        got_c.delete();
        i_sen.send_frame(lines, nb, base);
        repeat (40) @(posedge sys_clk);
    endtask

    task frame(input logic [31:0] ctrl, input int lines, input int nb, input logic [7:0] base);
        wr(`SIZE_OFS, {5'h00, 11'(lines - 1), 5'h00, 11'(nb - 1)});
        wr(`CTRL_OFS, ctrl);
        cap(lines, nb, base);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_regs();
        rd_chk("ctrl", `CTRL_OFS, 32'(`CTRL_RST));
        rd_chk("size", `SIZE_OFS, `SIZE_RST);
        rd_chk("sync", `SYNC_OFS, `SYNC_RST);
        rd_chk("clkdiv", `CLKDIV_OFS, 32'(`CLKDIV_RST));
        apb(1'b0, 12'h020, 32'h0, rdv, errv);
        `CHK("unmapped err", 1'b1, errv);
        for (int f = 0; f < 10; f++)
        begin
            wr(`CTRL_OFS, 32'(f) << `CTRL_FMT_LSB);
            rd_chk("format", `CTRL_OFS, 32'(f) << `CTRL_FMT_LSB);
        end
        wr(`CTRL_OFS, 32'h0000_01E0);
        rd_chk("bad format", `CTRL_OFS, 32'h0);
        wr(`CTRL_OFS, 32'h0000_3022);
        rd_chk("reduction", `CTRL_OFS, 32'h0000_3022);
        wr(`CLKDIV_OFS, 32'h0);
        rd_chk("clkdiv low", `CLKDIV_OFS, 32'(`CLKDIV_MIN));
        wr(`CLKDIV_OFS, 32'h1FF);
        rd_chk("clkdiv high", `CLKDIV_OFS, 32'(`CLKDIV_MAX));
        wr(`STATUS_OFS, 32'h7);
        rd_chk("status ro", `STATUS_OFS, 32'h0);
    endtask

    task t_raw8();
        wr(`IRQ_EN_OFS, 32'h7);
        frame(32'h1, 2, 8, 8'h10);
        `CHK("raw count", 2, got_d.size());
        `CHK("raw word0", exp_word(8'h10, 1, 8'hFF), got_d[0]);
        `CHK("raw word1", exp_word(8'h18, 1, 8'hFF), got_d[1]);
        `CHK("raw chan", 2'h0, got_c[1]);
        rd_chk("status", `STATUS_OFS, 32'h6);
        `CHK("irq", 1'b1, irq);
        wr(`CLEAR_OFS, 32'h2);
        rd_chk("status kept", `STATUS_OFS, 32'h4);
        wr(`IRQ_EN_OFS, 32'h3);
        repeat (3) @(negedge sys_clk);
        `CHK("irq masked", 1'b0, irq);
        wr(`CLEAR_OFS, 32'h7);
    endtask

    task t_bw5();
        frame(32'h5, 1, 8, 8'hE3);
        `CHK("five bit", exp_word(8'hE3, 1, 8'h1F), got_d[0]);
        frame(32'h3, 1, 16, 8'h00);
        `CHK("four bit", exp_word(8'h01, 34, 8'hFF), got_d[0]);
        frame(32'h3021, 1, 8, 8'h5A);
        `CHK("reduced", exp_word(8'h5A, 1, 8'hF8), got_d[0]);
    endtask

    task t_skip(input logic [2:0] sk);
        int n;
        n = 0;
        wr(`CTRL_OFS, {20'h0, sk, 9'h001});
        for (int f = 0; f < 2 * (sk + 1); f++)
        begin
            cap(1, 8, 8'h80);
            n += got_d.size();
        end
        `CHK("skip words", 2, n);
    endtask

    task t_planar();
        int y;
        y = 0;
        frame(32'h0000_0121, 1, 32, 8'h40);
        `CHK("planar count", 4, got_d.size());
        foreach (got_d[i])
            if (got_c[i] == 2'h0)
            begin
                `CHK("luma", exp_word(8'h41 + 8'(16 * y), 2, 8'hFF), got_d[i]);
                y++;
            end
            else
                `CHK("chroma", exp_word(got_c[i] == 2'h1 ? 8'h40 : 8'h42, 4, 8'hFF), got_d[i]);
    endtask

    task t_ovf();
        int n;
        dma_ready <= 1'b0;
        frame(32'h1, 1, 256, 8'h00);
        rd_chk("overflow", `STATUS_OFS, 32'h7);
        dma_ready <= 1'b1;
        repeat (40) @(posedge sys_clk);
        n = got_d.size();
        `CHK("kept words", 17, n);
        `CHK("oldest kept", exp_word(8'h00, 1, 8'hFF), got_d[0]);
        rd_chk("ovf sticky", `STATUS_OFS, 32'h7);
        wr(`CLEAR_OFS, 32'h7);
    endtask

    task t_gen();
        int   c;
        logic v;
        wr(`CTRL_OFS, 32'h10);
        repeat (3) @(negedge sys_clk);
        `CHK("line oe", 1'b1, line_sync_oe);
        `CHK("frame oe", 1'b1, frame_sync_oe);
        wr(`CTRL_OFS, 32'h18);
        repeat (3) @(negedge sys_clk);
        `CHK("embedded oe", 1'b0, line_sync_oe);
        wr(`CLKDIV_OFS, 32'h3);
        repeat (2) @(sensor_clk_out);
        c = 0;
        v = sensor_clk_out;
        do
        begin
            @(negedge sys_clk);
            c++;
        end
        while (sensor_clk_out === v);
        `CHK("half period", 3 + 1, c - 1);
    endtask

    task give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        dma_ready = 1'b1;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs();
        t_raw8();
        t_bw5();
        t_skip(3'h1);
        t_skip(3'h7);
        t_planar();
        t_ovf();
        t_gen();
        give_verdict();
    end
endmodule

//--- src/cam_port.v
// Camera capture port: sensor pixel input, sync handling, formatting, FIFOs, DMA output.
// Assumes an APB master on sys_clk, a DMA engine on the dma_* port, and a sensor
// whose pixel clock stays at or below a quarter of sys_clk.
//
// What this block does
// - Pixel data is captured on sensor pixel clock edges found in the core clock.
// - Bus carries 4, 5 or 8 bits per pixel clock; only 4 is serial, two nibbles per byte.
// - Only eight data lines exist; 9 and 10 bit raw input is refused.
// - Line sync pin is two-way: sensor line strobe or generated horizontal sync.
// - Frame sync pin is two-way: sensor frame strobe or generated vertical sync.
// - Embedded start and end of active video codes are decoded on 4 and 8 bit buses.
// - Pre-processed RGB formats, including transparency variants, are accepted.
// - RGB 8:8:8 components can be reduced in precision before storing.
// - YCbCr 4:2:2 is stored packed or split into three planes.
// - Raw pixels are packed without reading their colour pattern.
// - Horizontal and vertical capture size programmable independently up to 2048.
// - Three 64-bit FIFOs buffer data: 16, 8 and 8 entries.
// - A programmable sensor clock is driven out by a divider.
// - Overflow, end of line and end of frame raise maskable interrupts.
// - Every frame or one frame in N, N from 2 to 8, is captured.
// - Received pixels are formatted into words before the DMA port.
// - Sync timing is programmable, generated inside or taken from the sensor.
`timescale 1ns/1ps
`include "cam_port_regs.vh"

module cam_port
(
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sensor_pixel_clock,
    input  wire [7:0]  pixel_data_bus,
    input  wire        line_sync_in,
    output reg         line_sync_out,
    output reg         line_sync_oe,
    input  wire        frame_sync_in,
    output reg         frame_sync_out,
    output reg         frame_sync_oe,
    output reg         sensor_clk_out,
    output reg         dma_valid,
    output reg  [1:0]  dma_chan,
    output reg  [63:0] dma_data,
    input  wire        dma_ready,
    output reg         irq
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [13:0] ctrl_q;
reg  [31:0] size_q;
reg  [31:0] sync_q;
reg  [8:0]  div_q;
reg  [2:0]  status_q;
reg  [2:0]  irq_en_q;
wire        en       = ctrl_q[`CTRL_EN_BIT];
wire [1:0]  bw       = ctrl_q[`CTRL_BW_LSB +: 2];
wire        emb      = ctrl_q[`CTRL_EMB_BIT];
wire        gen      = ctrl_q[`CTRL_GEN_BIT];
wire [3:0]  fmt      = ctrl_q[`CTRL_FMT_LSB +: 4];
wire [2:0]  skip     = ctrl_q[`CTRL_SKIP_LSB +: 3];
wire [1:0]  red      = ctrl_q[`CTRL_RED_LSB +: 2];
wire [10:0] h_last   = size_q[10:0];
wire [10:0] v_last   = size_q[`SIZE_V_LSB +: 11];
wire [2:0]  ev;
wire [2:0]  ovf;
wire        setup    = psel && !penable;
reg  [10:0] col_q;
reg  [10:0] line_q;
reg         frm_act_q;
wire        push;

function [7:0] sel_ofs;
    input [11:0] a;
    begin
        case (a)
            `CTRL_OFS:   sel_ofs = 8'h01;
            `SIZE_OFS:   sel_ofs = 8'h02;
            `SYNC_OFS:   sel_ofs = 8'h04;
            `CLKDIV_OFS: sel_ofs = 8'h08;
            `STATUS_OFS: sel_ofs = 8'h10;
            `CLEAR_OFS:  sel_ofs = 8'h20;
            `IRQ_EN_OFS: sel_ofs = 8'h40;
            `STATE_OFS:  sel_ofs = 8'h80;
            default:     sel_ofs = 8'h00;
        endcase
    end
endfunction

wire [7:0] hit = sel_ofs(paddr);
wire       wr  = psel && penable && pwrite;

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        ctrl_q   <= `CTRL_RST;
        size_q   <= `SIZE_RST;
        sync_q   <= `SYNC_RST;
        div_q    <= `CLKDIV_RST;
        irq_en_q <= 3'h0;
        status_q <= 3'h0;
        prdata   <= 32'h0000_0000;
        pready   <= 1'b0;
        pslverr  <= 1'b0;
        irq      <= 1'b0;
    end
    else
    begin
        pready <= 1'b1;
        if (setup)
        begin
            pslverr <= (hit == 8'h00);
            case (hit)
                8'h01:   prdata <= {18'h0, ctrl_q};
                8'h02:   prdata <= size_q;
                8'h04:   prdata <= sync_q;
                8'h08:   prdata <= {23'h0, div_q};
                8'h10:   prdata <= {29'h0, status_q};
                8'h40:   prdata <= {29'h0, irq_en_q};
                8'h80:   prdata <= {4'h0, frm_act_q, line_q, 5'h0, col_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
        if (wr && hit[0])
        begin
            ctrl_q <= pwdata[13:0];
            if (pwdata[`CTRL_FMT_LSB +: 4] > `FMT_YCC_PLANAR)
                ctrl_q[`CTRL_FMT_LSB +: 4] <= `FMT_RAW8;
        end
        if (wr && hit[1])
            size_q <= {5'h0, pwdata[26:16], 5'h0, pwdata[10:0]};
        if (wr && hit[2])
            sync_q <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
        if (wr && hit[3])
        begin
            if (pwdata[8:0] < `CLKDIV_MIN)
                div_q <= `CLKDIV_MIN;
            else if (pwdata[8:0] > `CLKDIV_MAX)
                div_q <= `CLKDIV_MAX;
            else
                div_q <= pwdata[8:0];
        end
        if (wr && hit[6])
            irq_en_q <= pwdata[2:0];
        // Set wins over clear
        status_q <= (status_q & ~((wr && hit[5]) ? pwdata[2:0] : 3'h0)) | ev;
        irq      <= |(status_q & irq_en_q);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sensor clock divider

reg [8:0] div_cnt_q;

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        div_cnt_q      <= 9'h000;
        sensor_clk_out <= 1'b0;
    end
    else if (div_cnt_q >= div_q)
    begin
        div_cnt_q      <= 9'h000;
        sensor_clk_out <= !sensor_clk_out;
    end
    else
        div_cnt_q <= div_cnt_q + 9'h001;
end

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and pixel clock edge

reg [10:0] s1_q;
reg [10:0] s2_q;
reg        pclk_prev_q;
wire       pclk_rise = s2_q[10] && !pclk_prev_q;

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        s1_q        <= 11'h000;
        s2_q        <= 11'h000;
        pclk_prev_q <= 1'b0;
    end
    else
    begin
        s1_q        <= {sensor_pixel_clock, frame_sync_in, line_sync_in, pixel_data_bus};
        s2_q        <= s1_q;
        pclk_prev_q <= s2_q[10];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Byte assembly from 8, 4 or 5 bit bus

reg       byte_v_q;
reg [7:0] byte_q;
reg       nib_q;
reg [3:0] nib_hi_q;

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        byte_v_q <= 1'b0;
        byte_q   <= 8'h00;
        nib_q    <= 1'b0;
        nib_hi_q <= 4'h0;
    end
    else
    begin
        byte_v_q <= 1'b0;
        if (pclk_rise && en)
        begin
            case (bw)
                `BW_4:
                begin
                    nib_q <= !nib_q;
                    if (nib_q)
                    begin
                        byte_v_q <= 1'b1;
                        byte_q   <= {nib_hi_q, s2_q[3:0]};
                    end
                    else
                        nib_hi_q <= s2_q[3:0];
                end
                `BW_5:
                begin
                    byte_v_q <= 1'b1;
                    byte_q   <= {3'h0, s2_q[4:0]};
                end
                default:
                begin
                    byte_v_q <= 1'b1;
                    byte_q   <= s2_q[7:0];
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sync sources: sensor pins, embedded codes, internal generator

reg  [23:0] sh_q;
reg  [1:0]  pre_q;
reg         emb_line_q;
reg         emb_frame_q;
reg  [11:0] hcnt_q;
reg  [11:0] vcnt_q;
wire        code = byte_v_q && (sh_q == 24'hFF_0000);
wire        line_act = emb ? emb_line_q : (gen ? line_sync_out : s2_q[8]);
wire        frame_act = emb ? emb_frame_q : (gen ? frame_sync_out : s2_q[9]);

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        sh_q        <= 24'h00_0000;
        pre_q       <= 2'h0;
        emb_line_q  <= 1'b0;
        emb_frame_q <= 1'b0;
    end
    else if (byte_v_q)
    begin
        sh_q <= {sh_q[15:0], byte_q};
        if (pre_q != 2'h0)
            pre_q <= pre_q - 2'h1;
        if (code && emb && (bw != `BW_5))
        begin
            emb_line_q  <= !byte_q[4];
            emb_frame_q <= !byte_q[5];
            if (!byte_q[4])
                pre_q <= `EMB_SKIP;
        end
    end
end

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        hcnt_q         <= 12'h000;
        vcnt_q         <= 12'h000;
        line_sync_out  <= 1'b0;
        frame_sync_out <= 1'b0;
        line_sync_oe   <= 1'b0;
        frame_sync_oe  <= 1'b0;
    end
    else
    begin
        line_sync_oe  <= gen && !emb;
        frame_sync_oe <= gen && !emb;
        if (pclk_rise && gen)
        begin
            if (hcnt_q >= sync_q[11:0])
            begin
                hcnt_q <= 12'h000;
                vcnt_q <= (vcnt_q >= sync_q[27:16]) ? 12'h000 : vcnt_q + 12'h001;
            end
            else
                hcnt_q <= hcnt_q + 12'h001;
            frame_sync_out <= (vcnt_q <= {1'b0, v_last});
            line_sync_out  <= (hcnt_q <= {1'b0, h_last}) && (vcnt_q <= {1'b0, v_last});
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Line and frame tracking, frame skip, events

reg        line_prev_q;
reg        frm_prev_q;
reg  [2:0] skip_cnt_q;
reg        take_q;
wire       line_end  = line_prev_q && !line_act;
wire       frame_end = frm_prev_q && !frame_act;

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        line_prev_q <= 1'b0;
        frm_prev_q  <= 1'b0;
        frm_act_q   <= 1'b0;
        skip_cnt_q  <= 3'h0;
        take_q      <= 1'b0;
        col_q       <= 11'h000;
        line_q      <= 11'h000;
    end
    else
    begin
        line_prev_q <= line_act;
        frm_prev_q  <= frame_act;
        frm_act_q   <= frame_act;
        if (frame_act && !frm_prev_q)
        begin
            line_q <= 11'h000;
            // Keep one frame of every skip+1
            skip_cnt_q <= (skip_cnt_q >= skip) ? 3'h0 : skip_cnt_q + 3'h1;
            take_q     <= (skip_cnt_q >= skip);
        end
        if (line_act && !line_prev_q)
            col_q <= 11'h000;
        else if (push && col_q != 11'h7FF)
            col_q <= col_q + 11'h001;
        if (line_end && line_q != 11'h7FF)
            line_q <= line_q + 11'h001;
    end
end

assign ev[`ST_OVF_BIT] = |ovf;
assign ev[`ST_EOL_BIT] = line_end && frame_act && en;
assign ev[`ST_EOF_BIT] = frame_end && en;

////////////////////////////////////////////////////////////////////////////////
// Formatting and routing

reg  [1:0] phase_q;
wire       in_win = (col_q <= h_last) && (line_q <= v_last);
assign     push   = byte_v_q && line_act && frame_act && take_q && in_win
                    && (!emb || (pre_q == 2'h0 && !code));
wire [7:0] src    = emb ? sh_q[23:16] : byte_q;
wire [7:0] fmask  = 8'hFF << red;
wire [7:0] pdata  = ((fmt == `FMT_RGB888) || (fmt == `FMT_RGBT888)) ? (src & fmask) : src;
reg  [2:0] route;

always @*
begin
    route = 3'b001;
    if (fmt == `FMT_YCC_PLANAR)
    begin
        case (phase_q)
            2'h0:    route = 3'b010;
            2'h2:    route = 3'b100;
            default: route = 3'b001;
        endcase
    end
end

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
        phase_q <= 2'h0;
    else if (line_act && !line_prev_q)
        phase_q <= 2'h0;
    else if (push)
        phase_q <= phase_q + 2'h1;
end

////////////////////////////////////////////////////////////////////////////////
// Packing into three FIFOs

wire [2:0]   ne;
wire [2:0]   pop;
wire [191:0] head;
wire         take_out = !dma_valid || dma_ready;

assign pop[0] = take_out && ne[0];
assign pop[1] = take_out && !ne[0] && ne[1];
assign pop[2] = take_out && !ne[0] && !ne[1] && ne[2];

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_fifo
        localparam [4:0] DEPTH = (gi == 0) ? `DEPTH_BIG : `DEPTH_SMALL;
        reg  [63:0] mem [0:15];
        reg  [63:0] pack_q;
        reg  [2:0]  bcnt_q;
        reg  [3:0]  wp_q;
        reg  [3:0]  rp_q;
        reg  [4:0]  fill_q;
        wire        bin  = push && route[gi];
        wire        word = bin && (bcnt_q == 3'h7);
        wire        full = (fill_q == DEPTH);
        wire        wr_w = word && !full;
        wire [3:0]  last = DEPTH[3:0] - 4'h1;

        assign ovf[gi]          = word && full;
        assign ne[gi]           = (fill_q != 5'h00);
        assign head[gi*64 +: 64] = mem[rp_q];

        always @(posedge sys_clk)
        begin
            if (wr_w)
                mem[wp_q] <= {pdata, pack_q[63:8]};
        end

        always @(posedge sys_clk or negedge nrst)
        begin
            if (!nrst)
            begin
                pack_q <= 64'h0;
                bcnt_q <= 3'h0;
                wp_q   <= 4'h0;
                rp_q   <= 4'h0;
                fill_q <= 5'h00;
            end
            else
            begin
                if (bin)
                begin
                    pack_q <= {pdata, pack_q[63:8]};
                    bcnt_q <= bcnt_q + 3'h1;
                end
                if (wr_w)
                    wp_q <= (wp_q == last) ? 4'h0 : wp_q + 4'h1;
                if (pop[gi])
                    rp_q <= (rp_q == last) ? 4'h0 : rp_q + 4'h1;
                if (wr_w && !pop[gi])
                    fill_q <= fill_q + 5'h01;
                else if (!wr_w && pop[gi])
                    fill_q <= fill_q - 5'h01;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// DMA output stage

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        dma_valid <= 1'b0;
        dma_chan  <= 2'h0;
        dma_data  <= 64'h0;
    end
    else if (take_out)
    begin
        dma_valid <= |ne;
        if (pop[0])
        begin
            dma_chan <= 2'h0;
            dma_data <= head[63:0];
        end
        else if (pop[1])
        begin
            dma_chan <= 2'h1;
            dma_data <= head[127:64];
        end
        else if (pop[2])
        begin
            dma_chan <= 2'h2;
            dma_data <= head[191:128];
        end
    end
end

endmodule

//--- src/cam_port_regs.vh
// Register map, field positions, reset values and counts of the camera capture port.
// Included by the capture port module and its bench.
`ifndef CAM_PORT_REGS_VH
`define CAM_PORT_REGS_VH

`define CTRL_OFS       12'h000
`define SIZE_OFS       12'h004
`define SYNC_OFS       12'h008
`define CLKDIV_OFS     12'h00C
`define STATUS_OFS     12'h010
`define CLEAR_OFS      12'h014
`define IRQ_EN_OFS     12'h018
`define STATE_OFS      12'h01C

`define CTRL_EN_BIT    0
`define CTRL_BW_LSB    1
`define CTRL_EMB_BIT   3
`define CTRL_GEN_BIT   4
`define CTRL_FMT_LSB   5
`define CTRL_SKIP_LSB  9
`define CTRL_RED_LSB   12
`define CTRL_RST       14'h0000
`define SIZE_V_LSB     16
`define SIZE_RST       32'h01DF_027F
`define SYNC_RST       32'h020C_031F
`define CLKDIV_RST     9'h001
`define CLKDIV_MIN     9'h001
`define CLKDIV_MAX     9'h1FB

`define ST_OVF_BIT     0
`define ST_EOL_BIT     1
`define ST_EOF_BIT     2

`define BW_8           2'h0
`define BW_4           2'h1
`define BW_5           2'h2

`define FMT_RAW8       4'h0
`define FMT_RGB888     4'h1
`define FMT_RGBT888    4'h2
`define FMT_RGB666     4'h3
`define FMT_RGB565     4'h4
`define FMT_RGB555     4'h5
`define FMT_RGBT555    4'h6
`define FMT_RGB444     4'h7
`define FMT_YCC_PACK   4'h8
`define FMT_YCC_PLANAR 4'h9

`define EMB_SKIP       2'h3
`define DEPTH_BIG      5'h10
`define DEPTH_SMALL    5'h08

`endif
